// >>> hw/ddr3_pd_monitor.sv
// device-side checker of power-down, odt and write-leveling command spacing
`default_nettype none
`include "ddr3_pd_regs.svh"
module ddr3_pd_monitor (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire ddr3_pd_pkg::cmd_type cmd,
  input wire logic cke,
  input wire logic odt,
  input wire logic writeChop4,
  input wire logic bc4Fixed,
  input wire logic [4:0] readLatency,
  input wire logic [4:0] writeLatency,
  input wire logic [4:0] writeRecovery,
  input wire logic dllFrozenPd,
  input wire logic wlProgram,
  input wire logic dqsDrive,
  input wire logic dqsRise,
  input wire logic initDone,
  output logic powerDown,
  output logic cmdSampled,
  output logic odtTermOn,
  output logic violation,
  output ddr3_pd_pkg::viol_type violationCode
);
  import ddr3_pd_pkg::*;

  function automatic logic [11:0] maxCyc(input int nck, input int ps);
    int cyc;
    cyc = `CYC_FROM_PS(ps);
    if (cyc < 1)
    begin
      cyc = 1;
    end
    maxCyc = (nck > cyc) ? 12'(nck) : 12'(cyc);
  endfunction

  localparam logic [11:0] XpCycles = maxCyc(`T_XP_NCK, `T_XP_PS);
  localparam logic [11:0] XpdllCycles = maxCyc(`T_XPDLL_NCK, `T_XPDLL_PS);
  localparam logic [11:0] CkeCycles = maxCyc(`T_CKE_NCK, `T_CKE_PS);
  localparam logic [11:0] ModCycles = maxCyc(`T_MOD_NCK, `T_MOD_PS);
  localparam logic [11:0] WrCycles = 12'(`CYC_FROM_PS(`T_WR_PS));
  // longest residency rounds down; 3510 cycles at this clock rate
  localparam logic [11:0] PdMaxCycles = 12'((`PD_MAX_REFI * `T_REFI_PS) / `CLK_PERIOD_PS);

  ////////////////////////////////////////////////////////////////////////////////////////
  // spacing counters

  logic guardLoad, xpLoad, xpdllLoad, odtLoad, wlLoad;
  logic [11:0] guardCycles, odtCycles;
  logic guardBusy, xpBusy, xpdllBusy, odtBusy, mrdBusy, dqsEnBusy;

  spacing_counter guardCnt (
    .ref_clk(ref_clk), .arst_n(arst_n), .load(guardLoad), .loadCycles(guardCycles),
    .busy(guardBusy));
  spacing_counter xpCnt (
    .ref_clk(ref_clk), .arst_n(arst_n), .load(xpLoad), .loadCycles(XpCycles),
    .busy(xpBusy));
  spacing_counter xpdllCnt (
    .ref_clk(ref_clk), .arst_n(arst_n), .load(xpdllLoad), .loadCycles(XpdllCycles),
    .busy(xpdllBusy));
  spacing_counter odtCnt (
    .ref_clk(ref_clk), .arst_n(arst_n), .load(odtLoad), .loadCycles(odtCycles),
    .busy(odtBusy));
  spacing_counter mrdCnt (
    .ref_clk(ref_clk), .arst_n(arst_n), .load(wlLoad), .loadCycles(12'(`T_WLMRD_NCK)),
    .busy(mrdBusy));
  spacing_counter dqsEnCnt (
    .ref_clk(ref_clk), .arst_n(arst_n), .load(wlLoad), .loadCycles(12'(`T_WLDQSEN_NCK)),
    .busy(dqsEnBusy));

  ////////////////////////////////////////////////////////////////////////////////////////
  // command decode and checks

  monitor_state_type state_reg;
  monitor_state_type state_next;
  logic isNop, isRead, isWrite, entry, exitPd, cmdLive, odtRise, odtFall;
  logic vioNow;
  viol_type vioCode;
  logic [11:0] wrBase;

  always_comb
  begin
    state_next = state_reg;
    isNop = (cmd == CMD_NOP) || (cmd == CMD_DES);
    isRead = (cmd == CMD_RD) || (cmd == CMD_RDA);
    isWrite = (cmd == CMD_WR) || (cmd == CMD_WRA);
    entry = !state_reg.inPd && !cke && state_reg.ckePrev;
    exitPd = state_reg.inPd && cke;
    // the bus is still sampled in the entry cycle and one cycle after
    cmdLive = !state_reg.inPd || state_reg.cpded;
    odtRise = odt && !state_reg.odtPrev;
    odtFall = !odt && state_reg.odtPrev;
    vioNow = 1'b0;
    vioCode = VIO_NONE;

    // fixed chop-4 shortens the write tail
    wrBase = {7'h00, writeLatency} + (bc4Fixed ? 12'(`WR_PDEN_BC4) : 12'(`WR_PDEN_BL8));
    guardLoad = cmdLive && !isNop;
    case (cmd)
      CMD_ACT, CMD_PRE, CMD_PREA, CMD_REF: guardCycles = 12'(`T_CMD_PDEN_NCK);
      CMD_RD, CMD_RDA: guardCycles = {7'h00, readLatency} + 12'(`RD_PDEN_EXTRA);
      CMD_WR: guardCycles = wrBase + WrCycles;
      CMD_WRA: guardCycles = wrBase + {7'h00, writeRecovery} + 12'h001;
      CMD_MRS: guardCycles = ModCycles;
      default: guardCycles = 12'h000;
    endcase

    xpLoad = exitPd;
    xpdllLoad = exitPd && state_reg.pdFrozen;
    odtLoad = odtRise;
    if (odtRise && isWrite && !writeChop4 && !bc4Fixed)
    begin
      odtCycles = 12'(`ODTH8_NCK);
    end
    else
    begin
      odtCycles = 12'(`ODTH4_NCK);
    end
    wlLoad = wlProgram;

    // every check counts clock edges only
    if (entry && guardBusy)
    begin
      vioNow = 1'b1;
      vioCode = VIO_PD_ENTRY;
    end
    else if ((entry || state_reg.cpded) && !isNop)
    begin
      vioNow = 1'b1;
      vioCode = VIO_CPDED;
    end
    else if (exitPd && state_reg.pdCount < CkeCycles)
    begin
      vioNow = 1'b1;
      vioCode = VIO_PD_SHORT;
    end
    else if (state_reg.inPd && !cke && state_reg.pdCount >= PdMaxCycles)
    begin
      vioNow = 1'b1;
      vioCode = VIO_PD_LONG;
    end
    else if (!state_reg.inPd && !isNop && xpBusy)
    begin
      vioNow = 1'b1;
      vioCode = VIO_XP;
    end
    // only reads and synchronous odt wait for the dll
    else if (!state_reg.inPd && (isRead || odtRise) && xpdllBusy)
    begin
      vioNow = 1'b1;
      vioCode = VIO_XPDLL;
    end
    else if (odtFall && odtBusy)
    begin
      vioNow = 1'b1;
      vioCode = VIO_ODT;
    end
    else if (dqsRise && mrdBusy)
    begin
      vioNow = 1'b1;
      vioCode = VIO_WLMRD;
    end
    else if (dqsDrive && dqsEnBusy)
    begin
      vioNow = 1'b1;
      vioCode = VIO_WLDQSEN;
    end

    // power-down state
    state_next.ckePrev = cke;
    state_next.odtPrev = odt;
    state_next.odtTermOn = odt;
    state_next.cpded = entry;
    if (entry)
    begin
      state_next.inPd = 1'b1;
      state_next.pdCount = 12'h001;
      // open rows mean active power-down, where the dll keeps running
      state_next.pdFrozen = dllFrozenPd && !state_reg.rowsOpen;
    end
    else if (exitPd)
    begin
      state_next.inPd = 1'b0;
      state_next.pdCount = 12'h000;
    end
    else if (state_reg.inPd && state_reg.pdCount != 12'hfff)
    begin
      state_next.pdCount = state_reg.pdCount + 12'h001;
    end
    if (cmdLive && cmd == CMD_ACT)
    begin
      state_next.rowsOpen = 1'b1;
    end
    else if (cmdLive && (cmd == CMD_PRE || cmd == CMD_PREA))
    begin
      // single-bank precharge is treated as closing all rows
      state_next.rowsOpen = 1'b0;
    end

    // sticky until re-initialization; a new fault beats the clear
    if (vioNow)
    begin
      state_next.violation = 1'b1;
      if (!state_reg.violation)
      begin
        state_next.violationCode = vioCode;
      end
    end
    else if (initDone)
    begin
      state_next.violation = 1'b0;
      state_next.violationCode = VIO_NONE;
    end
    state_next.cmdSampled = !state_next.violation && (!state_next.inPd || state_next.cpded);
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= '{ckePrev: 1'b0, odtPrev: 1'b0, inPd: 1'b0, cpded: 1'b0,
                     pdFrozen: 1'b0, rowsOpen: 1'b0, pdCount: 12'h000,
                     cmdSampled: 1'b1, odtTermOn: 1'b0, violation: 1'b0,
                     violationCode: VIO_NONE};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign powerDown = state_reg.inPd;
  assign cmdSampled = state_reg.cmdSampled;
  assign odtTermOn = state_reg.odtTermOn;
  assign violation = state_reg.violation;
  assign violationCode = state_reg.violationCode;

endmodule
`default_nettype wire

// >>> hw/ddr3_pd_pkg.sv
// types shared by the spacing monitor and its counters
`default_nettype none
package ddr3_pd_pkg;

  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_DES = 4'h1,
    CMD_ACT = 4'h2,
    CMD_PRE = 4'h3,
    CMD_PREA = 4'h4,
    CMD_REF = 4'h5,
    CMD_RD = 4'h6,
    CMD_RDA = 4'h7,
    CMD_WR = 4'h8,
    CMD_WRA = 4'h9,
    CMD_MRS = 4'ha,
    CMD_ZQC = 4'hb
  } cmd_type;

  typedef enum logic [3:0] {
    VIO_NONE = 4'h0,
    VIO_PD_ENTRY = 4'h1,
    VIO_CPDED = 4'h2,
    VIO_PD_SHORT = 4'h3,
    VIO_PD_LONG = 4'h4,
    VIO_XP = 4'h5,
    VIO_XPDLL = 4'h6,
    VIO_ODT = 4'h7,
    VIO_WLMRD = 4'h8,
    VIO_WLDQSEN = 4'h9
  } viol_type;

  typedef struct packed {
    logic [11:0] remain;
  } counter_state_type;

  typedef struct packed {
    logic ckePrev;
    logic odtPrev;
    logic inPd;
    logic cpded;
    logic pdFrozen;
    logic rowsOpen;
    logic [11:0] pdCount;
    logic cmdSampled;
    logic odtTermOn;
    logic violation;
    viol_type violationCode;
  } monitor_state_type;

endpackage
`default_nettype wire

// >>> hw/ddr3_pd_regs.svh
// timing constants for the power-down, odt and write-leveling spacing monitor
`ifndef DDR3_PD_REGS_SVH
`define DDR3_PD_REGS_SVH

`define CLK_PERIOD_PS 20000
`define CYC_FROM_PS(p) (((p) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`define T_XP_NCK 3
`define T_XP_PS 6000
`define T_XPDLL_NCK 10
`define T_XPDLL_PS 24000
`define T_CKE_NCK 3
`define T_CKE_PS 5625
`define T_MOD_NCK 12
`define T_MOD_PS 15000
`define T_WR_PS 15000
`define T_REFI_PS 7800000
`define PD_MAX_REFI 9
`define T_CPDED_NCK 1
`define T_CMD_PDEN_NCK 1
`define RD_PDEN_EXTRA 5
`define WR_PDEN_BL8 4
`define WR_PDEN_BC4 2
`define ODTH4_NCK 4
`define ODTH8_NCK 6
`define T_WLMRD_NCK 40
`define T_WLDQSEN_NCK 25
`define CNT_W 12

`endif

// >>> hw/spacing_counter.sv
// down-counter holding the remaining cycles of one spacing constraint
`default_nettype none
module spacing_counter (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [11:0] loadCycles,
  output logic busy
);
  import ddr3_pd_pkg::*;

  counter_state_type state_reg;
  counter_state_type state_next;
  logic [11:0] decremented;
  logic [11:0] candidate;

  always_comb
  begin
    state_next = state_reg;
    decremented = (state_reg.remain != 12'h000) ? state_reg.remain - 12'h001 : 12'h000;
    // the load cycle itself counts as the first edge of the spacing
    candidate = (loadCycles > 12'h001) ? loadCycles - 12'h001 : 12'h000;
    state_next.remain = decremented;
    // a newer trigger never shortens a wait already running
    if (load && candidate > decremented)
    begin
      state_next.remain = candidate;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign busy = (state_reg.remain != 12'h000);

endmodule
`default_nettype wire

// >>> verification/ctrl_model.sv
// controller model driving commands, cke, odt and strobes
`default_nettype none
module ctrl_model (
  input wire logic ref_clk,
  output var ddr3_pd_pkg::cmd_type cmd,
  output var logic cke,
  output var logic odt,
  output var logic wlProgram,
  output var logic dqsRise,
  output var logic dqsDrive
);
  timeunit 1ns;
  timeprecision 1ns;
  import ddr3_pd_pkg::*;
  initial
  begin
    cmd = CMD_NOP;
    cke = 1'b1;
    odt = 1'b0;
    {wlProgram, dqsRise, dqsDrive} = 3'h0;
  end
  // one edge per step
  // spacing comes only from step counts, so a caller sets every gap
  task automatic step(input cmd_type c, input logic k, input logic o,
                      input logic [2:0] s = 3'h0);
    @(posedge ref_clk);
    #1;
    cmd = c;
    cke = k;
    odt = o;
    {wlProgram, dqsRise, dqsDrive} = s;
  endtask
endmodule
`default_nettype wire

// >>> verification/pd_spacing_monitor.sv
// concurrent checks of the spacing monitor ports
`default_nettype none
module pd_spacing_checker (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire ddr3_pd_pkg::cmd_type cmd,
  input wire logic cke,
  input wire logic odt,
  input wire logic wlProgram,
  input wire logic dqsRise,
  input wire logic dqsDrive,
  input wire logic initDone,
  input wire logic powerDown,
  input wire logic cmdSampled,
  input wire logic violation,
  input wire ddr3_pd_pkg::viol_type violationCode
);
  timeunit 1ns;
  timeprecision 1ns;
  import ddr3_pd_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  //////////////////////////////////////////////////////////////////////////////
  // past reset guard: the design ignores a cke fall right after release
  sequence s_entry;
    !cke && $past(cke) && !powerDown && $past(arst_n);
  endsequence
  sequence s_exit;
    powerDown && cke;
  endsequence
  property p_enter;
    s_entry |=> powerDown && (cmdSampled || violation) ##1 !cmdSampled;
  endproperty
  a_enter: assert property (p_enter)
    else $error("entry not followed by one pass cycle");
  property p_exit;
    s_exit |=> !powerDown;
  endproperty
  a_exit: assert property (p_exit)
    else $error("power-down not left on exit");
  property p_xp;
    s_exit ##1 (cmd != CMD_NOP && cmd != CMD_DES) |=> violation;
  endproperty
  a_xp: assert property (p_xp)
    else $error("early command after exit not flagged");
  property p_short;
    s_entry ##1 cke |=> violation;
  endproperty
  a_short: assert property (p_short)
    else $error("short power-down not flagged");
  property p_odt;
    $rose(odt) ##1 odt [*2] ##1 !odt |=> violation;
  endproperty
  a_odt: assert property (p_odt)
    else $error("short odt pulse not flagged");
  property p_wl;
    wlProgram ##[1:39] dqsRise |=> violation;
  endproperty
  a_wl: assert property (p_wl)
    else $error("early strobe rise not flagged");
  property p_stick;
    violation && !initDone |=> violation && $stable(violationCode);
  endproperty
  a_stick: assert property (p_stick)
    else $error("fault flag or code not held");
  property p_mute;
    violation |-> !cmdSampled;
  endproperty
  a_mute: assert property (p_mute)
    else $error("commands sampled after fault");
  // the entry cycle and the pass cycle both carry only nop or deselect
  property p_cpded;
    s_entry ##[0:1] (cmd != CMD_NOP && cmd != CMD_DES) |=> violation;
  endproperty
  a_cpded: assert property (p_cpded)
    else $error("command in pass cycle not flagged");
  property p_dqsen;
    wlProgram ##[1:24] dqsDrive |=> violation;
  endproperty
  a_dqsen: assert property (p_dqsen)
    else $error("early strobe drive not flagged");
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench of the spacing monitor
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ddr3_pd_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic bc4Fixed = 1'b0;
  logic initDone = 1'b0;
  logic dllFrozenPd = 1'b0;
  logic writeChop4 = 1'b0;
  cmd_type cmd;
  logic cke, odt, wlProgram, dqsRise, dqsDrive;
  logic powerDown, cmdSampled, odtTermOn, violation;
  viol_type violationCode;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  always #10 ref_clk = ~ref_clk;
  ctrl_model ctl (.ref_clk(ref_clk), .cmd(cmd), .cke(cke), .odt(odt),
    .wlProgram(wlProgram), .dqsRise(dqsRise), .dqsDrive(dqsDrive));
  ddr3_pd_monitor uut (.ref_clk(ref_clk), .arst_n(arst_n), .cmd(cmd), .cke(cke),
    .odt(odt), .writeChop4(writeChop4), .bc4Fixed(bc4Fixed), .readLatency(5'h05),
    .writeLatency(5'h05), .writeRecovery(5'h06), .dllFrozenPd(dllFrozenPd),
    .wlProgram(wlProgram), .dqsDrive(dqsDrive), .dqsRise(dqsRise),
    .initDone(initDone), .powerDown(powerDown), .cmdSampled(cmdSampled),
    .odtTermOn(odtTermOn), .violation(violation), .violationCode(violationCode));
  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (failures == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // judge the fault flag, then clear it so the next case starts clean
  task automatic verdict(input logic bad, input viol_type code);
    chk("violation", {3'h0, bad}, {3'h0, violation});
    if (bad)
      chk("code", code, violationCode);
    initDone = 1'b1;
    ctl.step(CMD_NOP, 1'b1, 1'b0);
    initDone = 1'b0;
    repeat (2) ctl.step(CMD_NOP, 1'b1, 1'b0);
    chk("cleared", 4'h0, {3'h0, violation});
  endtask
  task automatic walk;
    ctl.step(CMD_NOP, 1'b1, 1'b0);
    repeat (2) ctl.step(CMD_NOP, 1'b0, 1'b0);
    chk("pass", 4'h3, {2'h0, powerDown, cmdSampled});
    ctl.step(CMD_NOP, 1'b0, 1'b0);
    chk("blind", 4'h0, {3'h0, cmdSampled});
    ctl.step(CMD_NOP, 1'b1, 1'b0);
    ctl.step(CMD_ACT, 1'b1, 1'b0);
    chk("awake", 4'h1, {2'h0, powerDown, cmdSampled});
    ctl.step(CMD_NOP, 1'b1, 1'b0);
    chk("muted", 4'h0, {3'h0, cmdSampled});
    verdict(1'b1, VIO_XP);
  endtask
  task automatic short_pd;
    ctl.step(CMD_NOP, 1'b1, 1'b0);
    ctl.step(CMD_NOP, 1'b0, 1'b0);
    repeat (5) ctl.step(CMD_NOP, 1'b1, 1'b0);
    verdict(1'b1, VIO_PD_SHORT);
  endtask
  task automatic pden(input cmd_type c, input int gap, input logic bad);
    ctl.step(c, 1'b1, 1'b0);
    repeat (gap - 1) ctl.step(CMD_NOP, 1'b1, 1'b0);
    repeat (3) ctl.step(CMD_NOP, 1'b0, 1'b0);
    repeat (5) ctl.step(CMD_NOP, 1'b1, 1'b0);
    verdict(bad, VIO_PD_ENTRY);
  endtask
  task automatic odt_pulse(input cmd_type c, input int hold, input logic bad);
    ctl.step(c, 1'b1, 1'b1);
    repeat (hold - 1) ctl.step(CMD_NOP, 1'b1, 1'b1);
    ctl.step(CMD_NOP, 1'b1, 1'b0);
    chk("odtTermOn", 4'h1, {3'h0, odtTermOn});
    ctl.step(CMD_NOP, 1'b1, 1'b0);
    chk("odtTermOn low", 4'h0, {3'h0, odtTermOn});
    verdict(bad, VIO_ODT);
  endtask
  task automatic leveling(input logic rise, input int gap, input logic bad);
    ctl.step(CMD_NOP, 1'b1, 1'b0, 3'h4);
    repeat (gap - 1) ctl.step(CMD_NOP, 1'b1, 1'b0);
    ctl.step(CMD_NOP, 1'b1, 1'b0, rise ? 3'h2 : 3'h1);
    repeat (2) ctl.step(CMD_NOP, 1'b1, 1'b0);
    verdict(bad, rise ? VIO_WLMRD : VIO_WLDQSEN);
  endtask
  // entry, a chosen command in the pass cycle, cke low for low cycles in all
  task automatic pd_stay(input cmd_type c2, input int low, input logic bad,
                         input viol_type code);
    ctl.step(CMD_NOP, 1'b1, 1'b0);
    ctl.step(CMD_NOP, 1'b0, 1'b0);
    ctl.step(c2, 1'b0, 1'b0);
    repeat (low - 2) ctl.step(CMD_NOP, 1'b0, 1'b0);
    repeat (5) ctl.step(CMD_NOP, 1'b1, 1'b0);
    verdict(bad, code);
  endtask
  // first decides active or precharge power-down; c comes gap cycles after exit
  task automatic xpdll(input cmd_type first, input cmd_type c, input logic o,
                       input int gap, input logic bad);
    ctl.step(first, 1'b1, 1'b0);
    ctl.step(CMD_NOP, 1'b1, 1'b0);
    repeat (3) ctl.step(CMD_NOP, 1'b0, 1'b0);
    ctl.step(CMD_NOP, 1'b1, 1'b0);
    repeat (gap - 1) ctl.step(CMD_NOP, 1'b1, 1'b0);
    ctl.step(c, 1'b1, o);
    // odt, when raised, stays up long enough to keep its own limit
    repeat (4) ctl.step(CMD_NOP, 1'b1, o);
    ctl.step(CMD_NOP, 1'b1, 1'b0);
    verdict(bad, VIO_XPDLL);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    walk();
    short_pd();
    pd_stay(CMD_REF, 3, 1'b1, VIO_CPDED);
    pd_stay(CMD_DES, 3, 1'b0, VIO_NONE);
    pd_stay(CMD_NOP, 3510, 1'b0, VIO_NONE);
    pd_stay(CMD_NOP, 3511, 1'b1, VIO_PD_LONG);
    pden(CMD_ACT, 1, 1'b0);
    pden(CMD_PREA, 1, 1'b0);
    pden(CMD_REF, 1, 1'b0);
    pden(CMD_RD, 9, 1'b1);
    pden(CMD_RDA, 10, 1'b0);
    pden(CMD_WR, 9, 1'b1);
    pden(CMD_WR, 10, 1'b0);
    pden(CMD_WRA, 15, 1'b1);
    pden(CMD_MRS, 11, 1'b1);
    pden(CMD_MRS, 12, 1'b0);
    bc4Fixed = 1'b1;
    pden(CMD_WR, 7, 1'b1);
    pden(CMD_WRA, 14, 1'b0);
    odt_pulse(CMD_NOP, 3, 1'b1);
    odt_pulse(CMD_NOP, 4, 1'b0);
    odt_pulse(CMD_WR, 4, 1'b0);
    bc4Fixed = 1'b0;
    odt_pulse(CMD_WR, 6, 1'b0);
    odt_pulse(CMD_WR, 5, 1'b1);
    writeChop4 = 1'b1;
    odt_pulse(CMD_WR, 4, 1'b0);
    writeChop4 = 1'b0;
    dllFrozenPd = 1'b1;
    xpdll(CMD_PRE, CMD_RD, 1'b0, 9, 1'b1);
    xpdll(CMD_PREA, CMD_RDA, 1'b0, 10, 1'b0);
    xpdll(CMD_PRE, CMD_NOP, 1'b1, 9, 1'b1);
    xpdll(CMD_PREA, CMD_ACT, 1'b0, 3, 1'b0);
    xpdll(CMD_ACT, CMD_RD, 1'b0, 3, 1'b0);
    dllFrozenPd = 1'b0;
    leveling(1'b1, 39, 1'b1);
    leveling(1'b1, 40, 1'b0);
    leveling(1'b0, 24, 1'b1);
    leveling(1'b0, 25, 1'b0);
    stop_test();
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 12000)
    begin
      failures++;
      stop_test();
    end
  end
endmodule
bind ddr3_pd_monitor pd_spacing_checker chk_i (.ref_clk(ref_clk), .arst_n(arst_n),
  .cmd(cmd), .cke(cke), .odt(odt), .wlProgram(wlProgram), .dqsRise(dqsRise),
  .dqsDrive(dqsDrive),
  .initDone(initDone), .powerDown(powerDown), .cmdSampled(cmdSampled),
  .violation(violation), .violationCode(violationCode));
`default_nettype wire
